// ### ccd_pkg.sv
// package: opcodes, field layout, widths and reset values for the execution slice
package ccd_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int INSN_W = 14;
  localparam int FADDR_W = 7;
  localparam int STACK_DEPTH = 8;
  // ------------------------------------------------------------
  // opcode patterns (14-bit words)
  // ------------------------------------------------------------
  localparam logic [13:0] OP_WDT_CLEAR = 14'h0064;
  localparam logic [13:0] OP_ACC_CLEAR = 14'h0100;
  localparam logic [6:0] OP_FCLR_HI = 7'h03;
  localparam logic [5:0] OP_FILE_COMPLEMENT_OP_HI = 6'h09;
  localparam logic [5:0] OP_FILE_DECREMENT_OP_HI = 6'h03;
  localparam logic [3:0] OP_BTSC_HI = 4'h6;
  localparam logic [2:0] OP_CALL_HI = 3'h4;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int DEST_BIT = 7;
  localparam int BIT_LSB = 7;
  localparam int LATCH_LO = 3;
  localparam int PC_SPLIT = 11;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [13:0] NOP_WORD = 14'h0000;

  typedef struct packed {
    logic zero;
    logic timeout_flag_n;
    logic powerdown_flag_n;
  } ccd_flags_t;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } ccd_fwrite_t;

  typedef enum logic [3:0] {
    CCD_NONE, CCD_WDT_CLEAR, CCD_ACC_CLEAR, CCD_FILE_CLEAR, CCD_COMPLEMENT,
    CCD_DECREMENT, CCD_BTSC, CCD_CALL
  } ccd_op_t;
endpackage : ccd_pkg

// ### ccd_exec.sv
// execution slice: skip-if-clear, call, watchdog clear, clears, complement, decrement
// How it works
// - skip-if-clear with tested bit clear discards next word, runs nop: two cycles.
// - call pushes current pc plus one onto stack top before jumping.
// - call loads its eleven-bit immediate into pc bits 10..0.
// - call takes pc bits 12..11 from pc high latch bits 4..3.
// - call lasts two cycles and leaves every status flag unchanged.
// - watchdog clear zeroes the watchdog counter; it has no operands.
// - watchdog clear also zeroes the watchdog prescaler.
// - watchdog clear sets the time-out and power-down flags (active low) to one.
// - file clear writes zero to the addressed register and sets zero flag.
// - accumulator clear zeroes the accumulator and sets zero flag.
// - complement inverts the addressed register and updates zero flag.
// - complement destination bit 0 writes accumulator, 1 writes the register.
// - decrement subtracts one from the addressed register and updates zero flag.
// - decrement destination bit 0 writes accumulator, 1 writes the register.
`timescale 1ns/1ps
`default_nettype none
module ccd_exec (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // program memory
  output logic [12:0] prog_addr_out,
  input wire logic [13:0] prog_data_in,
  // file register read port (combinational, addressed by fetched word)
  output logic [6:0] file_raddr_out,
  input wire logic [7:0] file_rdata_in,
  // file register write port
  output ccd_pkg::ccd_fwrite_t file_wr_out,
  // high latch and watchdog
  input wire logic [7:0] pc_high_latch_in,
  output logic watchdog_clear_out,
  output logic prescaler_clear_out,
  // state visible outside
  output logic [7:0] acc_out,
  output ccd_pkg::ccd_flags_t flags_out,
  output logic [12:0] stack_top_out,
  output logic [3:0] stack_ptr_out,
  output logic busy_out
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [12:0] pc;
  logic [7:0] acc;
  ccd_pkg::ccd_flags_t flags;
  logic [12:0] stack_mem [ccd_pkg::STACK_DEPTH];
  logic [2:0] sp;
  logic [3:0] depth;
  logic flush;
  ccd_pkg::ccd_op_t op;
  logic [13:0] insn;
  logic dest_file;
  logic [7:0] comp_res;
  logic [7:0] dec_res;
  logic tested_bit;
  logic [12:0] call_target;

  // a flushed word is replaced by nop so the skipped/branched slot costs one cycle
  assign insn = flush ? ccd_pkg::NOP_WORD : prog_data_in;
  assign dest_file = insn[ccd_pkg::DEST_BIT];
  assign file_raddr_out = insn[6:0];
  assign comp_res = ~file_rdata_in;
  assign dec_res = file_rdata_in - 8'h01;
  assign tested_bit = file_rdata_in[insn[9:7]];
  assign call_target = {pc_high_latch_in[4:ccd_pkg::LATCH_LO], insn[10:0]};

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  always_comb begin
    op = ccd_pkg::CCD_NONE;
    if (insn == ccd_pkg::OP_WDT_CLEAR) begin
      op = ccd_pkg::CCD_WDT_CLEAR;
    end else if (insn == ccd_pkg::OP_ACC_CLEAR) begin
      op = ccd_pkg::CCD_ACC_CLEAR;
    end else if (insn[13:7] == ccd_pkg::OP_FCLR_HI) begin
      op = ccd_pkg::CCD_FILE_CLEAR;
    end else if (insn[13:8] == ccd_pkg::OP_FILE_COMPLEMENT_OP_HI) begin
      op = ccd_pkg::CCD_COMPLEMENT;
    end else if (insn[13:8] == ccd_pkg::OP_FILE_DECREMENT_OP_HI) begin
      op = ccd_pkg::CCD_DECREMENT;
    end else if (insn[13:10] == ccd_pkg::OP_BTSC_HI) begin
      op = ccd_pkg::CCD_BTSC;
    end else if (insn[13:11] == ccd_pkg::OP_CALL_HI) begin
      op = ccd_pkg::CCD_CALL;
    end
  end

  // ------------------------------------------------------------
  // program counter and flush slot
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pc <= ccd_pkg::PC_RESET;
      flush <= 1'b0;
    end else begin
      case (op)
        ccd_pkg::CCD_CALL: begin
          pc <= call_target;
          flush <= 1'b1;
        end
        ccd_pkg::CCD_BTSC: begin
          pc <= pc + 13'h0001;
          flush <= ~tested_bit;
        end
        default: begin
          pc <= pc + 13'h0001;
          flush <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // return stack: circular, eight entries, overflow wraps
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sp <= 3'h0;
      depth <= 4'h0;
    end else if (op == ccd_pkg::CCD_CALL) begin
      sp <= sp + 3'h1;
      if (depth != 4'h8) begin
        depth <= depth + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (op == ccd_pkg::CCD_CALL) begin
      stack_mem[sp] <= pc + 13'h0001;
    end
  end

  // ------------------------------------------------------------
  // accumulator
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc <= ccd_pkg::ACC_RESET;
    end else begin
      case (op)
        ccd_pkg::CCD_ACC_CLEAR: acc <= ccd_pkg::ZERO_BYTE;
        ccd_pkg::CCD_COMPLEMENT: if (!dest_file) acc <= comp_res;
        ccd_pkg::CCD_DECREMENT: if (!dest_file) acc <= dec_res;
        default: acc <= acc;
      endcase
    end
  end

  // ------------------------------------------------------------
  // status flags; call and skip leave them alone
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flags <= '{zero: 1'b0, timeout_flag_n: 1'b1, powerdown_flag_n: 1'b1};
    end else begin
      case (op)
        ccd_pkg::CCD_WDT_CLEAR: begin
          flags.timeout_flag_n <= 1'b1;
          flags.powerdown_flag_n <= 1'b1;
        end
        ccd_pkg::CCD_ACC_CLEAR: flags.zero <= 1'b1;
        ccd_pkg::CCD_FILE_CLEAR: flags.zero <= 1'b1;
        ccd_pkg::CCD_COMPLEMENT: flags.zero <= (comp_res == ccd_pkg::ZERO_BYTE);
        ccd_pkg::CCD_DECREMENT: flags.zero <= (dec_res == ccd_pkg::ZERO_BYTE);
        default: flags <= flags;
      endcase
    end
  end

  // ------------------------------------------------------------
  // file write port and watchdog pulses, registered
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      file_wr_out <= '0;
    end else begin
      file_wr_out.addr <= insn[6:0];
      case (op)
        ccd_pkg::CCD_FILE_CLEAR: begin
          file_wr_out.we <= 1'b1;
          file_wr_out.data <= ccd_pkg::ZERO_BYTE;
        end
        ccd_pkg::CCD_COMPLEMENT: begin
          file_wr_out.we <= dest_file;
          file_wr_out.data <= comp_res;
        end
        ccd_pkg::CCD_DECREMENT: begin
          file_wr_out.we <= dest_file;
          file_wr_out.data <= dec_res;
        end
        default: begin
          file_wr_out.we <= 1'b0;
          file_wr_out.data <= ccd_pkg::ZERO_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      watchdog_clear_out <= 1'b0;
      prescaler_clear_out <= 1'b0;
    end else begin
      watchdog_clear_out <= (op == ccd_pkg::CCD_WDT_CLEAR);
      prescaler_clear_out <= (op == ccd_pkg::CCD_WDT_CLEAR);
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prog_addr_out = pc;
  assign acc_out = acc;
  assign flags_out = flags;
  assign stack_top_out = (depth == 4'h0) ? ccd_pkg::PC_RESET : stack_mem[sp - 3'h1];
  assign stack_ptr_out = depth;
  assign busy_out = flush;
endmodule : ccd_exec
`default_nettype wire

// ### ccd_exec_sva.sv
// checker: port-level properties of the execution slice
`timescale 1ns/1ps
`default_nettype none
module ccd_exec_sva (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // watched ports
  input wire logic [12:0] prog_addr_out,
  input wire logic [13:0] prog_data_in,
  input wire logic [7:0] file_rdata_in,
  input wire ccd_pkg::ccd_fwrite_t file_wr_out,
  input wire logic [7:0] pc_high_latch_in,
  input wire logic watchdog_clear_out,
  input wire logic prescaler_clear_out,
  input wire logic [7:0] acc_out,
  input wire ccd_pkg::ccd_flags_t flags_out,
  input wire logic [12:0] stack_top_out,
  input wire logic busy_out
);
  // ----------------------------------------
  // decode of the word taken this cycle
  // ----------------------------------------
  logic ex;
  logic [13:0] w;
  assign ex = !busy_out;
  assign w = prog_data_in;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  AST_SKIP: assert property (ex && w[13:10] == ccd_pkg::OP_BTSC_HI && !file_rdata_in[w[9:7]]
    |=> busy_out ##1 (!busy_out && prog_addr_out == $past(prog_addr_out, 2) + 13'h0002))
    else $error("skip did not flush one word");
  AST_PUSH: assert property (ex && w[13:11] == ccd_pkg::OP_CALL_HI
    |=> stack_top_out == $past(prog_addr_out) + 13'h0001) else $error("bad return address");
  AST_CALL_PC: assert property (ex && w[13:11] == ccd_pkg::OP_CALL_HI
    |=> prog_addr_out == {$past(pc_high_latch_in[4:3]), $past(w[10:0])}) else $error("bad target");
  AST_CALL_FLAGS: assert property (ex && w[13:11] == ccd_pkg::OP_CALL_HI
    |=> busy_out && $stable(flags_out)) else $error("call changed flags");
  AST_WDT: assert property (ex && w == ccd_pkg::OP_WDT_CLEAR
    |=> watchdog_clear_out && prescaler_clear_out && flags_out[1:0] == 2'h3)
    else $error("watchdog clear incomplete");
  AST_FCLR: assert property (ex && w[13:7] == ccd_pkg::OP_FCLR_HI
    |=> file_wr_out == {1'b1, $past(w[6:0]), 8'h00} && flags_out.zero) else $error("file clear");
  AST_ACLR: assert property (ex && w == ccd_pkg::OP_ACC_CLEAR
    |=> acc_out == 8'h00 && flags_out.zero) else $error("acc clear");
  AST_FILE_COMPLEMENT_OP: assert property (ex && w[13:8] == ccd_pkg::OP_FILE_COMPLEMENT_OP_HI && !w[7]
    |=> acc_out == ~$past(file_rdata_in) && flags_out.zero == (acc_out == 8'h00))
    else $error("complement");
  AST_FILE_DECREMENT_OP: assert property (ex && w[13:8] == ccd_pkg::OP_FILE_DECREMENT_OP_HI && w[7]
    |=> file_wr_out.we && file_wr_out.data == $past(file_rdata_in) - 8'h01)
    else $error("decrement");
endmodule : ccd_exec_sva
bind ccd_exec ccd_exec_sva u_ccd_exec_sva (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
  .prog_addr_out(prog_addr_out), .prog_data_in(prog_data_in), .file_rdata_in(file_rdata_in),
  .file_wr_out(file_wr_out), .pc_high_latch_in(pc_high_latch_in), .acc_out(acc_out),
  .watchdog_clear_out(watchdog_clear_out), .prescaler_clear_out(prescaler_clear_out),
  .flags_out(flags_out), .stack_top_out(stack_top_out), .busy_out(busy_out));
`default_nettype wire

// ### ccd_prog_mem.sv
// partner: program memory plus file register array
`timescale 1ns/1ps
`default_nettype none
module ccd_prog_mem (
  // clock
  input wire logic clk_sys_in,
  // program and file ports
  input wire logic [12:0] prog_addr_in,
  output logic [13:0] prog_data_out,
  input wire logic [6:0] file_raddr_in,
  output logic [7:0] file_rdata_out,
  input wire ccd_pkg::ccd_fwrite_t file_wr_in
);
  // ----------------------------------------
  // storage, loaded by the bench
  // ----------------------------------------
  logic [13:0] mem [0:8191];
  logic [7:0] regs [0:127];
  // reads are combinational: the core samples them in the same cycle
  assign prog_data_out = mem[prog_addr_in];
  assign file_rdata_out = regs[file_raddr_in];
  always @(posedge clk_sys_in) begin
    if (file_wr_in.we) regs[file_wr_in.addr] <= file_wr_in.data;
  end
endmodule : ccd_prog_mem
`default_nettype wire

// ### test_core_call_clear_decrement_exec.sv
// testbench: runs a short program through the execution slice
`timescale 1ns/1ps
`default_nettype none
module test_core_call_clear_decrement_exec;
  // ----------------------------------------
  // signals and program rows
  // ----------------------------------------
  typedef struct packed {
    logic [13:0] word;
    logic [12:0] pc;
    logic [7:0] acc;
    logic [1:0] zb;
  } ccd_row_t;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] pc_high_latch_in = 8'h08;
  logic [12:0] prog_addr_out, stack_top_out;
  logic [13:0] prog_data_in;
  logic [6:0] file_raddr_out;
  logic [7:0] file_rdata_in, acc_out;
  logic [3:0] stack_ptr_out;
  logic watchdog_clear_out, prescaler_clear_out, busy_out;
  ccd_pkg::ccd_fwrite_t file_wr_out;
  ccd_pkg::ccd_flags_t flags_out;
  int err_count = 0;
  int tests_run = 0;
  logic [7:0] fdat [8] = '{8'h5A, 8'h01, 8'hFF, 8'h00, 8'h80, 8'h33, 8'h00, 8'h04};
  // word at each address, then pc, acc and {zero, busy} after it is taken
  ccd_row_t rows [15] = '{
    '{14'h0100, 13'h0001, 8'h00, 2'h2}, '{14'h0910, 13'h0002, 8'hA5, 2'h0},
    '{14'h0311, 13'h0003, 8'h00, 2'h2}, '{14'h0393, 13'h0004, 8'h00, 2'h0},
    '{14'h0992, 13'h0005, 8'h00, 2'h2}, '{14'h0314, 13'h0006, 8'h7F, 2'h0},
    '{14'h0195, 13'h0007, 8'h7F, 2'h2}, '{14'h0064, 13'h0008, 8'h7F, 2'h2},
    '{14'h1916, 13'h0009, 8'h7F, 2'h3}, '{14'h0100, 13'h000A, 8'h7F, 2'h2},
    '{14'h1917, 13'h000B, 8'h7F, 2'h2}, '{14'h0910, 13'h000C, 8'hA5, 2'h0},
    '{14'h2040, 13'h0840, 8'hA5, 2'h1}, '{14'h0000, 13'h0841, 8'hA5, 2'h0},
    '{14'h0100, 13'h0842, 8'h00, 2'h2}};
  always #4 clk_sys_in = ~clk_sys_in;
  ccd_exec u_ccd_exec (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .prog_addr_out(prog_addr_out),
    .prog_data_in(prog_data_in),
    .file_raddr_out(file_raddr_out),
    .file_rdata_in(file_rdata_in),
    .file_wr_out(file_wr_out),
    .pc_high_latch_in(pc_high_latch_in),
    .watchdog_clear_out(watchdog_clear_out),
    .prescaler_clear_out(prescaler_clear_out),
    .acc_out(acc_out),
    .flags_out(flags_out),
    .stack_top_out(stack_top_out),
    .stack_ptr_out(stack_ptr_out),
    .busy_out(busy_out)
  );
  ccd_prog_mem u_ccd_prog_mem (.clk_sys_in(clk_sys_in), .prog_addr_in(prog_addr_out),
    .prog_data_out(prog_data_in), .file_raddr_in(file_raddr_out),
    .file_rdata_out(file_rdata_in), .file_wr_in(file_wr_out));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    foreach (u_ccd_prog_mem.mem[i]) u_ccd_prog_mem.mem[i] = 14'h0000;
    foreach (rows[i]) u_ccd_prog_mem.mem[i < 13 ? i : i + 2099] = rows[i].word;
    foreach (fdat[i]) u_ccd_prog_mem.regs[16 + i] = fdat[i];
    repeat (16) @(posedge clk_sys_in);
    #1 resetn_in = 1'b1;
    // one row per edge; the call target word is flushed, hence the nop there
    foreach (rows[i]) begin
      @(posedge clk_sys_in);
      #1;
      check("pc", 16'(rows[i].pc), 16'(prog_addr_out));
      check("acc", 16'(rows[i].acc), 16'(acc_out));
      check("zero_busy", 16'(rows[i].zb), 16'({flags_out.zero, busy_out}));
      if (i == 7) check("wdt", 16'h0003, 16'({watchdog_clear_out, prescaler_clear_out}));
      if (i == 8) check("wdt_end", 16'h0000, 16'({watchdog_clear_out, prescaler_clear_out}));
      if (i == 12) check("stack", 16'h000D, 16'(stack_top_out));
      if (i == 12) check("depth", 16'h0001, 16'(stack_ptr_out));
    end
    check("dec_wb", 16'h00FF, 16'(u_ccd_prog_mem.regs[19]));
    check("com_wb", 16'h0000, 16'(u_ccd_prog_mem.regs[18]));
    check("clr_wb", 16'h0000, 16'(u_ccd_prog_mem.regs[21]));
    check("no_wb", 16'h005A, 16'(u_ccd_prog_mem.regs[16]));
    // second reset in mid-run must restore the reset state
    resetn_in = 1'b0;
    #20;
    check("reset", 16'h0003, 16'({acc_out, stack_ptr_out, flags_out[1:0]}));
    check("reset_pc", 16'h0000, 16'(prog_addr_out));
    report_and_stop();
  end
endmodule : test_core_call_clear_decrement_exec
`default_nettype wire
